/* hdl/tdsl_top.sv */
// Purpose: Steering, guard-time qualification and latched 4-bit digit output
// Assumes: Front end supplies tone presence and row/column; RC network on guard pin
// Notes:   Guard times are set by the external RC; this logic only times fixed delays
`timescale 1ns/1ps
`default_nettype none
module tdsl_top
   import tdsl_pkg::*;
#(
   parameter int PRESENCE_CYCLES = PRESENCE_CYC,
   parameter int ABSENCE_CYCLES = ABSENCE_CYC,
   parameter int POWER_UP_CYCLES = POWER_UP_CYC
)
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // Tone front end
   input wire logic TONE_PRESENT,
   input wire logic [1:0] TONE_ROW,
   input wire logic [1:0] TONE_COL,
   // Power control
   input wire logic POWER_DOWN_INPUT,
   // Guard RC pin
   input wire logic GUARD_RC_PIN_IN,
   output logic GUARD_RC_PIN_OUT,
   output logic GUARD_RC_PIN_OE,
   // Steering flags
   output logic EARLY_TONE_FLAG,
   output logic QUALIFIED_DIGIT_FLAG,
   // Digit code outputs
   input wire logic CODE_DRIVE_ENABLE,
   output logic [CODE_W-1:0] DIGIT_CODE_OUTPUTS,
   output logic DIGIT_CODE_OE
);

   ////////////////////////////////////////////////////////////////////////////
   // Local constants
   localparam int WAKE_CYCLES = (POWER_UP_CYCLES > PRESENCE_CYCLES) ?
      (POWER_UP_CYCLES - PRESENCE_CYCLES) : 1;
   localparam logic [CNT_W-1:0] PRESENCE_LIM = PRESENCE_CYCLES[CNT_W-1:0];
   localparam logic [CNT_W-1:0] ABSENCE_LIM = ABSENCE_CYCLES[CNT_W-1:0];
   localparam logic [CNT_W-1:0] WAKE_LIM = WAKE_CYCLES[CNT_W-1:0];
   localparam logic [CNT_W-1:0] CODE_LIM = CODE_DELAY_CYC[CNT_W-1:0];
   localparam logic [CNT_W-1:0] FLAG_LIM = FLAG_DELAY_CYC[CNT_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // State types
   typedef enum logic [2:0] {
      PW_DOWN = 3'b001,
      PW_WAKE = 3'b010,
      PW_RUN = 3'b100
   } tdsl_power_t;

   typedef enum logic [3:0] {
      SQ_IDLE = 4'b0001,
      SQ_CODE_WAIT = 4'b0010,
      SQ_FLAG_WAIT = 4'b0100,
      SQ_HELD = 4'b1000
   } tdsl_steer_t;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   tdsl_tone_t tone_raw;
   tdsl_tone_t tone;
   logic pd_sync;
   logic steer_sync;
   logic drive_sync;
   logic early;
   logic running;
   logic [PAIR_W-1:0] held_pair;
   logic [CNT_W-1:0] wake_count;
   logic [CNT_W-1:0] steer_count;
   logic [CODE_W-1:0] code_latch;
   logic qualified;
   tdsl_power_t power_state;
   tdsl_power_t next_power_state;
   tdsl_steer_t steer_state;
   tdsl_steer_t next_steer_state;

   assign tone_raw.present = TONE_PRESENT;
   assign tone_raw.row = TONE_ROW;
   assign tone_raw.col = TONE_COL;
   assign running = (power_state == PW_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   tdsl_sync3 #(.W(TONE_W)) u_sync_tone
   (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d(tone_raw),
      .q(tone)
   );

   tdsl_sync3 #(.W(3)) u_sync_ctl
   (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d({POWER_DOWN_INPUT, GUARD_RC_PIN_IN, CODE_DRIVE_ENABLE}),
      .q({pd_sync, steer_sync, drive_sync})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power-down and wake sequencing
   always_comb
   begin
      next_power_state = power_state;
      unique case (power_state)
         PW_DOWN:
            if (!pd_sync)
               next_power_state = PW_WAKE;
         PW_WAKE:
            if (pd_sync)
               next_power_state = PW_DOWN;
            else if (wake_count + 1'b1 >= WAKE_LIM)
               next_power_state = PW_RUN;
         PW_RUN:
            if (pd_sync)
               next_power_state = PW_DOWN;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         power_state <= PW_WAKE;
      else
         power_state <= next_power_state;
   end

   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         wake_count <= '0;
      else if (power_state == PW_WAKE)
         wake_count <= wake_count + 1'b1;
      else
         wake_count <= '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Early flag: presence and absence detect on raw frequencies
   tdsl_qualify u_early
   (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .clear(!running),
      .level(tone.present),
      .rise_cnt(PRESENCE_LIM),
      .fall_cnt(ABSENCE_LIM),
      .flag(early)
   );

   // Remember the pair seen while frequencies are valid
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         held_pair <= '0;
      else if (early && tone.present)
         held_pair <= {tone.row, tone.col};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Steering sequence on the sensed RC level
   always_comb
   begin
      next_steer_state = steer_state;
      unique case (steer_state)
         SQ_IDLE:
            if (steer_sync && early)
               next_steer_state = SQ_CODE_WAIT;
         SQ_CODE_WAIT:
            if (!steer_sync)
               next_steer_state = SQ_IDLE;
            else if (steer_count + 1'b1 >= CODE_LIM)
               next_steer_state = SQ_FLAG_WAIT;
         SQ_FLAG_WAIT:
            if (!steer_sync)
               next_steer_state = SQ_IDLE;
            else if (steer_count + 1'b1 >= FLAG_LIM)
               next_steer_state = SQ_HELD;
         SQ_HELD:
            if (!steer_sync)
               next_steer_state = SQ_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         steer_state <= SQ_IDLE;
      else if (!running)
         steer_state <= SQ_IDLE;
      else
         steer_state <= next_steer_state;
   end

   // Delay counter from the steering crossing
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         steer_count <= '0;
      else if (!running || steer_state == SQ_IDLE || steer_state == SQ_HELD)
         steer_count <= '0;
      else
         steer_count <= steer_count + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code latch: loads only when the code delay expires
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         code_latch <= CODE_RESET;
      else if (running && steer_state == SQ_CODE_WAIT && steer_sync &&
               steer_count + 1'b1 >= CODE_LIM)
         code_latch <= tdsl_decode(held_pair);
   end

   // Qualified flag: high through dropouts shorter than the RC hold
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         qualified <= 1'b0;
      else
         qualified <= running && (next_steer_state == SQ_HELD);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drive
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         DIGIT_CODE_OUTPUTS <= CODE_RESET;
         DIGIT_CODE_OE <= 1'b0;
      end
      else
      begin
         DIGIT_CODE_OUTPUTS <= code_latch;
         DIGIT_CODE_OE <= drive_sync;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         EARLY_TONE_FLAG <= 1'b0;
         QUALIFIED_DIGIT_FLAG <= 1'b0;
      end
      else
      begin
         EARLY_TONE_FLAG <= early;
         QUALIFIED_DIGIT_FLAG <= qualified;
      end
   end

   // RC network charged from the early flag, released in power-down
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         GUARD_RC_PIN_OUT <= 1'b0;
         GUARD_RC_PIN_OE <= 1'b0;
      end
      else
      begin
         GUARD_RC_PIN_OUT <= early;
         GUARD_RC_PIN_OE <= running;
      end
   end

endmodule // tdsl_top
`default_nettype wire

/* hdl/tdsl_pkg.sv */
// Purpose: Shared constants, types and decode table for the tone digit steering latch
// Assumes: REF_CLK at 125 MHz; times held in microseconds, except the code setup time in nanoseconds
// Notes:   Long cycle counts are defaults for top-level parameters
package tdsl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_MHZ = 125;
   localparam int CNT_W = 23;
   // Presence detect time: 5 min, 11 typ, 14 max (ms)
   localparam int PRESENCE_DETECT_US = 11000;
   // Absence detect time: 0.5 min, 4 typ, 8.5 max (ms)
   localparam int ABSENCE_DETECT_US = 4000;
   // Power-up time from release of power-down to early flag (ms)
   localparam int POWER_UP_US = 30000;
   // Steering crossing to code update (typ 8 us, max 11 us)
   localparam int CODE_DELAY_US = 8;
   // Steering crossing to qualified flag (typ 12 us, max 16 us)
   localparam int FLAG_DELAY_US = 12;
   // Code setup before qualified flag, typ 3.4 us
   localparam int SETUP_NS = 3400;

   localparam int PRESENCE_CYC = PRESENCE_DETECT_US * CLK_MHZ;
   localparam int ABSENCE_CYC = ABSENCE_DETECT_US * CLK_MHZ;
   localparam int POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
   localparam int CODE_DELAY_CYC = CODE_DELAY_US * CLK_MHZ;
   localparam int FLAG_DELAY_CYC = FLAG_DELAY_US * CLK_MHZ;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // Front-end bundle and code widths
   localparam int CODE_W = 4;
   localparam int PAIR_W = 4;
   localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;

   typedef struct packed {
      logic present;
      logic [1:0] row;
      logic [1:0] col;
   } tdsl_tone_t;

   localparam int TONE_W = $bits(tdsl_tone_t);

   // Sixteen 4-bit codes, entry n at bits [4n+3:4n], n = row*4 + col
   localparam logic [63:0] DIGIT_TABLE = 64'h0cab_fe98_d765_e432 ^ 64'h0000_0000_0000_0001;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed pair-to-code decode
   function automatic logic [CODE_W-1:0] tdsl_decode(input logic [PAIR_W-1:0] pair);
      tdsl_decode = DIGIT_TABLE[{pair, 2'b00} +: CODE_W];
   endfunction

endpackage

/* hdl/tdsl_sync3.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tdsl_sync3
   import tdsl_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser chain
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accept a change once the last two stages agree
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         q <= '0;
      else if (stage2 == stage3)
         q <= stage3;
   end

endmodule // tdsl_sync3
`default_nettype wire

/* hdl/tdsl_qualify.sv */
// Purpose: Level qualifier with separate rise and fall persistence counts
// Assumes: Counts are at least one cycle
// Notes:   Clear forces the flag low and restarts timing
`timescale 1ns/1ps
`default_nettype none
module tdsl_qualify
   import tdsl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic clear,
   input wire logic level,
   input wire logic [CNT_W-1:0] rise_cnt,
   input wire logic [CNT_W-1:0] fall_cnt,
   // Result
   output logic flag
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;

   assign limit = flag ? fall_cnt : rise_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Count while level differs from flag, toggle when the limit is met
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count <= '0;
         flag <= 1'b0;
      end
      else if (clear)
      begin
         count <= '0;
         flag <= 1'b0;
      end
      else if (level == flag)
         count <= '0;
      else if (count + 1'b1 >= limit)
      begin
         count <= '0;
         flag <= level;
      end
      else
         count <= count + 1'b1;
   end

endmodule // tdsl_qualify
`default_nettype wire

/* sim/tdsl_top_checker.sv */
// Purpose: Port assertions for tdsl_top
// Assumes: Bound to every tdsl_top
// Notes:   Run counters time input persistence
`timescale 1ns/1ps
`default_nettype none
module tdsl_top_checker
   import tdsl_pkg::*;
#(
   parameter int PRESENCE_CYCLES = PRESENCE_CYC,
   parameter int ABSENCE_CYCLES = ABSENCE_CYC,
   parameter int POWER_UP_CYCLES = POWER_UP_CYC
)
(
   // Clock
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // Inputs
   input wire logic TONE_PRESENT,
   input wire logic GUARD_RC_PIN_IN,
   input wire logic CODE_DRIVE_ENABLE,
   // Outputs
   input wire logic GUARD_RC_PIN_OUT,
   input wire logic GUARD_RC_PIN_OE,
   input wire logic EARLY_TONE_FLAG,
   input wire logic QUALIFIED_DIGIT_FLAG,
   input wire logic [CODE_W-1:0] DIGIT_CODE_OUTPUTS,
   input wire logic DIGIT_CODE_OE
);
   int t_run;
   int s_run;
   int age;

   ////////////////////////////////////////////////////////////////////////////
   // Cycles since tone, steering and code last changed
   always_ff @(posedge REF_CLK or negedge ARST_N)
      if (!ARST_N)
      begin
         t_run <= 0;
         s_run <= 0;
         age <= 0;
      end
      else
      begin
         t_run <= $changed(TONE_PRESENT) ? 0 : t_run + 1;
         s_run <= $changed(GUARD_RC_PIN_IN) ? 0 : s_run + 1;
         age <= $changed(DIGIT_CODE_OUTPUTS) ? 0 : age + 1;
      end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence oe_on;
      ##[2:6] DIGIT_CODE_OE;
   endsequence
   sequence oe_off;
      ##[2:6] !DIGIT_CODE_OE;
   endsequence

   chk_early_rise: assert property ($rose(EARLY_TONE_FLAG) |->
      TONE_PRESENT && t_run >= PRESENCE_CYCLES) else $error("early flag rose too soon");
   chk_early_fall: assert property ($fell(EARLY_TONE_FLAG) |->
      !TONE_PRESENT && t_run >= ABSENCE_CYCLES) else $error("early flag fell too soon");
   chk_flag_rise: assert property ($rose(QUALIFIED_DIGIT_FLAG) |->
      GUARD_RC_PIN_IN && s_run >= FLAG_DELAY_CYC) else $error("flag rose unguarded");
   chk_flag_fall: assert property ($fell(QUALIFIED_DIGIT_FLAG) |->
      !GUARD_RC_PIN_IN && s_run inside {[2:10]}) else $error("flag fell wrongly");
   chk_code_change: assert property ($changed(DIGIT_CODE_OUTPUTS) |->
      GUARD_RC_PIN_IN && s_run >= CODE_DELAY_CYC) else $error("code changed unguarded");
   chk_code_setup: assert property ($rose(QUALIFIED_DIGIT_FLAG) |->
      age >= FLAG_DELAY_CYC - CODE_DELAY_CYC - 10) else $error("code not set up");
   chk_rc_drive: assert property (GUARD_RC_PIN_OE |->
      GUARD_RC_PIN_OUT == EARLY_TONE_FLAG) else $error("guard pin not early flag");
   chk_oe_on: assert property ($rose(CODE_DRIVE_ENABLE) |-> oe_on)
      else $error("code pins not driven");
   chk_oe_off: assert property ($fell(CODE_DRIVE_ENABLE) |-> oe_off)
      else $error("code pins not floated");
endmodule // tdsl_top_checker

bind tdsl_top tdsl_top_checker #(.PRESENCE_CYCLES(PRESENCE_CYCLES),
   .ABSENCE_CYCLES(ABSENCE_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES)) i_tdsl_top_checker (
   .REF_CLK, .ARST_N, .TONE_PRESENT, .GUARD_RC_PIN_IN, .CODE_DRIVE_ENABLE, .GUARD_RC_PIN_OUT,
   .GUARD_RC_PIN_OE, .EARLY_TONE_FLAG, .QUALIFIED_DIGIT_FLAG, .DIGIT_CODE_OUTPUTS,
   .DIGIT_CODE_OE);
`default_nettype wire

/* sim/tdsl_host.sv */
// Purpose: Host and RC network beside tdsl_top
// Assumes: Guard times given in cycles
// Notes:   Captures the code on each qualified flag rise while the code pins are driven
`timescale 1ns/1ps
`default_nettype none
module tdsl_host
   import tdsl_pkg::*;
#(
   parameter int RC_RISE = 60,
   parameter int RC_FALL = 150
)
(
   // Clock
   input wire logic clk,
   input wire logic arst_n,
   // Guard pin
   input wire logic rc_out,
   input wire logic rc_oe,
   output logic steer,
   // Code pins
   input wire logic qual,
   input wire logic [CODE_W-1:0] code,
   input wire logic code_oe,
   output logic [CODE_W-1:0] cap_code,
   output logic [31:0] cap_n
);
   logic rc_lvl;
   logic qual_q;
   logic [CODE_W-1:0] bus;
   logic [CODE_W-1:0] last;
   int run;

   // Undriven node bleeds low; floating code pins show the inverse
   assign rc_lvl = rc_oe & rc_out;
   assign bus = code_oe ? code : ~last;

   // Steering crosses threshold after charge or discharge time
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         run <= 0;
         steer <= 1'h0;
      end
      else if (rc_lvl == steer)
         run <= 0;
      else if (run >= (rc_lvl ? RC_RISE : RC_FALL))
      begin
         run <= 0;
         steer <= rc_lvl;
      end
      else
         run <= run + 1;

   // Read on the rising qualified flag
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         qual_q <= 1'h0;
         last <= 4'h0;
         cap_code <= 4'h0;
         cap_n <= 32'h0;
      end
      else
      begin
         qual_q <= qual;
         if (code_oe)
            last <= code;
         if (qual && !qual_q && code_oe)
         begin
            cap_code <= bus;
            cap_n <= cap_n + 32'h1;
         end
      end
endmodule // tdsl_host
`default_nettype wire

/* sim/tdsl_top_tb.sv */
// Purpose: Self-checking bench for tdsl_top
// Assumes: Short guard counts; host closes the RC loop
// Notes:   Row table, then burst, dropout, power and reset
`timescale 1ns/1ps
`default_nettype none
module tdsl_top_tb
   import tdsl_pkg::*;
;
   localparam int PRE = 50;
   localparam int ABS = 20;
   localparam int PU = 100;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic pres = 1'h0;
   logic pd = 1'h0;
   logic en = 1'h1;
   logic [1:0] row = 2'h0;
   logic [1:0] col = 2'h0;
   logic steer, rc_out, rc_oe, early, qual, code_oe;
   logic [3:0] code, cap_code;
   logic [31:0] cap_n;
   logic [8:0] rows [16];
   logic [1:0] h;
   int n_mismatch = 0;
   int checked = 0;
   int n;

   always #4 clk = ~clk;

   tdsl_top #(.PRESENCE_CYCLES(PRE), .ABSENCE_CYCLES(ABS), .POWER_UP_CYCLES(PU)) i_tdsl_top (
      .REF_CLK(clk), .ARST_N(arst_n), .TONE_PRESENT(pres), .TONE_ROW(row), .TONE_COL(col),
      .POWER_DOWN_INPUT(pd), .GUARD_RC_PIN_IN(steer), .GUARD_RC_PIN_OUT(rc_out),
      .GUARD_RC_PIN_OE(rc_oe), .EARLY_TONE_FLAG(early), .QUALIFIED_DIGIT_FLAG(qual),
      .CODE_DRIVE_ENABLE(en), .DIGIT_CODE_OUTPUTS(code), .DIGIT_CODE_OE(code_oe));
   tdsl_host i_tdsl_host (.clk, .arst_n, .rc_out, .rc_oe, .steer, .qual, .code, .code_oe,
      .cap_code, .cap_n);

   ////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("mismatches %0d of %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tick;
      @(posedge clk);
      #1;
   endtask

   // Bounded wait on the early (0) or qualified (1) flag
   task wait_on(input logic q, input logic v);
      n = 0;
      while ((q ? qual : early) !== v)
      begin
         tick;
         n++;
         if (n > 4000)
         begin
            chk(n, 0);
            stop_test;
         end
      end
   endtask

   task run_row(input logic [8:0] r);
      logic [31:0] k;
      logic [3:0] c;
      k = cap_n;
      c = cap_code;
      en = r[8];
      {row, col} = r[7:4];
      pres = 1'h1;
      wait_on(0, 1);
      chk(n inside {[PRE + 3 : PRE + 7]}, 1);
      wait_on(1, 1);
      chk({code_oe, code}, {r[8], r[3:0]});
      pres = 1'h0;
      wait_on(0, 0);
      chk(n inside {[ABS + 3 : ABS + 7]}, 1);
      chk(cap_n - k, 32'(r[8]));
      chk(cap_code, r[8] ? r[3:0] : c);
      wait_on(1, 0);
      chk(code, r[3:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      for (int i = 0; i < 16; i++)
         rows[i] = {~i[0], 4'(i), DIGIT_TABLE[4 * i +: 4]};
      repeat (2) tick;
      chk({early, qual, code, code_oe, rc_oe}, 0);
      repeat (3) tick;
      arst_n = 1'h1;
      repeat (PU) tick;
      foreach (rows[i])
         run_row(rows[i]);
      // Burst shorter than the presence time
      en = 1'h1;
      {row, col} = 4'h5;
      pres = 1'h1;
      repeat (PRE - 20) tick;
      pres = 1'h0;
      h = 2'h0;
      repeat (200)
      begin
         tick;
         h = h | {early, qual};
      end
      chk({h, code}, {2'h0, rows[15][3:0]});
      // Dropout shorter than the absent guard time
      {row, col} = 4'h6;
      pres = 1'h1;
      wait_on(1, 1);
      pres = 1'h0;
      repeat (ABS + 10) tick;
      pres = 1'h1;
      h = 2'h3;
      repeat (200)
      begin
         tick;
         h = h & {qual, steer};
      end
      chk({h, code}, {2'h3, rows[6][3:0]});
      pres = 1'h0;
      wait_on(1, 0);
      // Wake from power-down with a tone present
      pd = 1'h1;
      repeat (10) tick;
      {row, col} = 4'h9;
      pres = 1'h1;
      repeat (20) tick;
      chk(early, 0);
      pd = 1'h0;
      wait_on(0, 1);
      chk(n inside {[PU : PU + 10]}, 1);
      wait_on(1, 1);
      chk(code, rows[9][3:0]);
      // Reset in mid-tone
      arst_n = 1'h0;
      repeat (2) tick;
      chk({early, qual, code, code_oe, rc_oe}, 0);
      // Release in mid-tone: full wake time again before the early flag
      arst_n = 1'h1;
      wait_on(0, 1);
      chk(n inside {[PU : PU + 10]}, 1);
      stop_test;
   end
endmodule // tdsl_top_tb
`default_nettype wire
